// File: shared/mcu_exec_map.svh
// offsets, field positions, reset values and bus responses of the executor
// assumes a 12-bit AXI4-Lite byte address and a 100 MHz aclk
//
// Function
// - add-immediate: acc += 8-bit literal, sets both carries and Z
// - add-register sums acc and 7-bit-addressed register; carries and Z
// - register ops: destination bit 0 writes acc, 1 writes the register
// - and-immediate ands acc with an 8-bit literal into acc, only Z
// - and-register ands acc with the register into destination, only Z
// - bit-clear zeroes the 3-bit-selected register bit, flags untouched
// - bit-set forces the selected register bit to one, flags untouched
// - test-skip-if-zero: bit zero discards next word, two-cycle nop
// - test-skip-if-one: bit one discards next word, two-cycle nop
// - call pushes pc+1, k into pc 10:0, latch bits 4:3 into pc 12:11
// - pc-changing or skipping ops take two cycles, the second a nop
`ifndef MCU_EXEC_MAP_SVH
`define MCU_EXEC_MAP_SVH

// register byte offsets
`define OFF_INSTR 12'h000
`define OFF_ACC 12'h004
`define OFF_STATUS 12'h008
`define OFF_PC 12'h00C
`define OFF_HIGH_LATCH 12'h010
`define OFF_STACK_TOP 12'h014
`define OFF_EXEC 12'h018
// data register window at 0x200..0x3FC, tag is address bits 11:9
`define WIN_TAG 3'h1

// status field positions
`define C_BIT 0
`define DIGIT_CARRY_BIT 1
`define Z_BIT 2
// execution status field positions
`define EXEC_NOP_BIT 0
`define EXEC_SKIP_BIT 1

// pc high latch bits that feed pc 12:11 on a call
`define LATCH_HI 4
`define LATCH_LO 3

// reset values
`define RST_ACC 8'h00
`define RST_STATUS 3'h0
`define RST_PC 13'h0000
`define RST_LATCH 5'h00
`define RST_INSTR 14'h0000
`define RST_SP 3'h0

// bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// File: shared/mcu_exec_pkg.sv
// types shared by the executor and its register store
// assumes the 14-bit instruction word of the mid-range set
package mcu_exec_pkg;

  // decoded operation of the implemented subset
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ADD_IMMEDIATE_TO_ACC = 4'h1,
    OP_ADD_ACC_AND_REG = 4'h2,
    OP_AND_IMMEDIATE_WITH_ACC = 4'h3,
    OP_AND_ACC_WITH_REG = 4'h4,
    OP_BIT_CLEAR = 4'h5,
    OP_BIT_SET = 4'h6,
    OP_TEST_SKIP_IF_ZERO = 4'h7,
    OP_TEST_SKIP_IF_ONE = 4'h8,
    OP_CALL = 4'h9
  } op_kind_t;

  // instruction cycle phase
  typedef enum logic [0:0] {
    CYC_READY = 1'b0,
    CYC_NOP = 1'b1
  } cyc_t;

  // opcode decode; anything outside the subset runs as a nop
  function automatic op_kind_t decode_op(input logic [13:0] w);
    op_kind_t k;
    k = OP_NOP;
    if (w[13:9] == 5'h1F) k = OP_ADD_IMMEDIATE_TO_ACC;
    else if (w[13:8] == 6'h39) k = OP_AND_IMMEDIATE_WITH_ACC;
    else if (w[13:8] == 6'h07) k = OP_ADD_ACC_AND_REG;
    else if (w[13:8] == 6'h05) k = OP_AND_ACC_WITH_REG;
    else if (w[13:10] == 4'h4) k = OP_BIT_CLEAR;
    else if (w[13:10] == 4'h5) k = OP_BIT_SET;
    else if (w[13:10] == 4'h6) k = OP_TEST_SKIP_IF_ZERO;
    else if (w[13:10] == 4'h7) k = OP_TEST_SKIP_IF_ONE;
    else if (w[13:11] == 3'h4) k = OP_CALL;
    return k;
  endfunction : decode_op

  // byte-lane merge of a bus write into an old word
  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : merge_lanes

endpackage : mcu_exec_pkg

// File: shared/regfile_if.sv
// carrier between the executor and the 128-entry data register store
// assumes one combinational read port and one clocked write port
`timescale 1ns/1ps
interface regfile_if;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  modport core (output rd_addr, input rd_data,
                output wr_en, output wr_addr, output wr_data);
  modport store (input rd_addr, output rd_data,
                 input wr_en, input wr_addr, input wr_data);
endinterface : regfile_if

// File: hw/data_regfile.sv
// 128 x 8 data register file in flip-flops
// assumes the executor never reads and writes a conflicting entry
`timescale 1ns/1ps
module data_regfile (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // access port
  regfile_if.store port
);

  logic [7:0] mem [128];

  // read is combinational so an instruction sees its operand at once
  assign port.rd_data = mem[port.rd_addr];

  // write port, cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 128; i++) mem[i] <= 8'h00;
    end else if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

endmodule : data_regfile

// File: hw/mcu_exec_top.sv
// instruction executor for a subset of the 14-bit set, behind AXI4-Lite
// assumes a master with one write and one read under way at a time
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "mcu_exec_map.svh"

module mcu_exec_top
  import mcu_exec_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  regfile_if rf ();

  // held write address and data
  logic aw_held;
  logic [11:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // core state
  logic [7:0] acc;
  logic [2:0] status;
  logic [12:0] pc;
  logic [4:0] high_latch;
  logic [13:0] instr;
  logic [12:0] stack [8];
  logic [2:0] sp;
  logic skip_pending;
  cyc_t cyc;

  ////////////////////////////////////////////////////////////////////////////
  // register store

  data_regfile u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(rf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes

  logic wr_do;
  logic rd_do;

  // a write executes once address and data are both held and no nop runs
  assign wr_do = aw_held & w_held & (cyc == CYC_READY);
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  // reads yield to a write so the single read port is never shared
  assign s_axi_arready = ~s_axi_rvalid & ~wr_do;
  assign rd_do = s_axi_arvalid & s_axi_arready;

  ////////////////////////////////////////////////////////////////////////////
  // write address decode

  logic hit_instr;
  logic hit_acc;
  logic hit_status;
  logic hit_pc;
  logic hit_latch;
  logic hit_ro;
  logic hit_win;
  logic w_mapped;

  assign hit_instr = aw_addr == `OFF_INSTR;
  assign hit_acc = aw_addr == `OFF_ACC;
  assign hit_status = aw_addr == `OFF_STATUS;
  assign hit_pc = aw_addr == `OFF_PC;
  assign hit_latch = aw_addr == `OFF_HIGH_LATCH;
  assign hit_ro = (aw_addr == `OFF_STACK_TOP) | (aw_addr == `OFF_EXEC);
  assign hit_win = (aw_addr[11:9] == `WIN_TAG) & (aw_addr[1:0] == 2'h0);
  assign w_mapped = hit_instr | hit_acc | hit_status | hit_pc | hit_latch
                    | hit_ro | hit_win;

  // merged values of writable registers
  logic [31:0] m_instr;
  logic [31:0] m_acc;
  logic [31:0] m_status;
  logic [31:0] m_pc;
  logic [31:0] m_latch;

  assign m_instr = merge_lanes({18'h0, instr}, w_data, w_strb);
  assign m_acc = merge_lanes({24'h0, acc}, w_data, w_strb);
  assign m_status = merge_lanes({29'h0, status}, w_data, w_strb);
  assign m_pc = merge_lanes({19'h0, pc}, w_data, w_strb);
  assign m_latch = merge_lanes({27'h0, high_latch}, w_data, w_strb);

  ////////////////////////////////////////////////////////////////////////////
  // instruction fields and decode

  logic issue;
  logic [13:0] word;
  op_kind_t kind;
  logic [6:0] f_addr;
  logic dest_reg;
  logic [2:0] bit_pos;
  logic [7:0] k8;
  logic [10:0] k11;

  // a write to the instruction register issues the word
  assign issue = wr_do & hit_instr;
  assign word = m_instr[13:0];
  // a word issued after a taken skip is discarded and runs as a nop
  assign kind = skip_pending ? OP_NOP : decode_op(word);
  assign f_addr = word[6:0];
  assign dest_reg = word[7];
  assign bit_pos = word[9:7];
  assign k8 = word[7:0];
  assign k11 = word[10:0];

  logic is_add_lit;
  logic is_add_reg;
  logic is_and_lit;
  logic is_and_reg;
  logic is_clr;
  logic is_set;
  logic is_tsz;
  logic is_tso;
  logic is_call;

  assign is_add_lit = kind == OP_ADD_IMMEDIATE_TO_ACC;
  assign is_add_reg = kind == OP_ADD_ACC_AND_REG;
  assign is_and_lit = kind == OP_AND_IMMEDIATE_WITH_ACC;
  assign is_and_reg = kind == OP_AND_ACC_WITH_REG;
  assign is_clr = kind == OP_BIT_CLEAR;
  assign is_set = kind == OP_BIT_SET;
  assign is_tsz = kind == OP_TEST_SKIP_IF_ZERO;
  assign is_tso = kind == OP_TEST_SKIP_IF_ONE;
  assign is_call = kind == OP_CALL;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic and logic

  logic [7:0] reg_val;
  logic [7:0] operand;
  logic [8:0] sum;
  logic [4:0] nib_sum;
  logic [7:0] and_res;
  logic [7:0] mask;
  logic [7:0] alu_res;
  logic is_add;
  logic is_and;

  // the read port serves the instruction during a write, else the reader
  assign rf.rd_addr = wr_do ? f_addr : s_axi_araddr[8:2];
  assign reg_val = rf.rd_data;
  assign operand = (is_add_lit | is_and_lit) ? k8 : reg_val;
  assign sum = {1'b0, acc} + {1'b0, operand};
  assign nib_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
  assign and_res = acc & operand;
  assign mask = 8'h01 << bit_pos;
  assign is_add = is_add_lit | is_add_reg;
  assign is_and = is_and_lit | is_and_reg;

  // result for the destination
  assign alu_res = is_add ? sum[7:0] :
                   is_and ? and_res :
                   is_clr ? (reg_val & ~mask) :
                   is_set ? (reg_val | mask) :
                   8'h00;

  // status after an affecting instruction
  logic [2:0] next_status;
  logic flags_touch;

  assign flags_touch = issue & (is_add | is_and);
  always_comb begin
    next_status = status;
    next_status[`Z_BIT] = alu_res == 8'h00;
    if (is_add) begin
      next_status[`C_BIT] = sum[8];
      next_status[`DIGIT_CARRY_BIT] = nib_sum[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // destinations, skip and program flow

  logic to_reg;
  logic to_acc;
  logic sel_bit;
  logic take_skip;
  logic two_cycle;
  logic win_wr;
  logic [12:0] pc_inc;
  logic [2:0] top_idx;

  // register ops pick acc or register; bit ops always write the register
  assign to_reg = issue & ((is_add_reg | is_and_reg) & dest_reg
                           | is_clr | is_set);
  assign to_acc = issue & (is_add_lit | is_and_lit
                  | (is_add_reg | is_and_reg) & ~dest_reg);
  assign sel_bit = reg_val[bit_pos];
  assign take_skip = issue & (is_tsz & ~sel_bit
                              | is_tso & sel_bit);
  assign two_cycle = take_skip | issue & is_call;
  assign win_wr = wr_do & hit_win & w_strb[0];
  assign pc_inc = pc + 13'h0001;
  assign top_idx = sp - 3'h1;

  // store write port: instruction result or a bus write to the window
  assign rf.wr_en = to_reg | win_wr;
  assign rf.wr_addr = issue ? f_addr : aw_addr[8:2];
  assign rf.wr_data = issue ? alu_res : w_data[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr[11:9] == `WIN_TAG && s_axi_araddr[1:0] == 2'h0) begin
      rd_word = {24'h0, rf.rd_data};
    end else begin
      case (s_axi_araddr)
        `OFF_INSTR: rd_word = {18'h0, instr};
        `OFF_ACC: rd_word = {24'h0, acc};
        `OFF_STATUS: rd_word = {29'h0, status};
        `OFF_PC: rd_word = {19'h0, pc};
        `OFF_HIGH_LATCH: rd_word = {27'h0, high_latch};
        `OFF_STACK_TOP: rd_word = {19'h0, stack[top_idx]};
        `OFF_EXEC: rd_word = {30'h0, skip_pending, cyc == CYC_NOP};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus channel registers

  // hold address and data until the write executes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response, one cycle after execution
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= w_mapped ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (rd_do) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator, status and latch

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= `RST_ACC;
      status <= `RST_STATUS;
      high_latch <= `RST_LATCH;
      instr <= `RST_INSTR;
    end else begin
      if (to_acc) acc <= alu_res;
      else if (wr_do && hit_acc) acc <= m_acc[7:0];
      // bit ops, tests and calls leave flags alone
      if (flags_touch) status <= next_status;
      else if (wr_do && hit_status) status <= m_status[2:0];
      if (wr_do && hit_latch) high_latch <= m_latch[4:0];
      if (issue) instr <= word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter, return stack and cycle phase

  // cycle phase: a two-cycle instruction blocks the next write one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc <= CYC_READY;
    end else begin
      case (cyc)
        CYC_READY: if (two_cycle) cyc <= CYC_NOP;
        CYC_NOP: cyc <= CYC_READY;
        default: cyc <= CYC_READY;
      endcase
    end
  end

  // skip flag marks the next issued word for discard
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_pending <= 1'b0;
    end else if (issue) begin
      skip_pending <= take_skip;
    end
  end

  // call loads k and latch bits; others step to the next word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc <= `RST_PC;
      sp <= `RST_SP;
      for (int i = 0; i < 8; i++) stack[i] <= `RST_PC;
    end else if (issue) begin
      if (is_call) begin
        stack[sp] <= pc_inc;
        sp <= sp + 3'h1;
        pc <= {high_latch[`LATCH_HI:`LATCH_LO], k11};
      end else begin
        pc <= pc_inc;
      end
    end else if (wr_do && hit_pc) begin
      pc <= m_pc[12:0];
    end
  end

endmodule : mcu_exec_top

// File: tb/prog_mem_model.sv
// program memory model: holds the skip test program, answers at once
// assumes the bench reads pc over the bus and fetches the word from here
`timescale 1ns/1ps
module prog_mem_model (
  // fetch port
  input wire logic [12:0] fetch_pc,
  output logic [13:0] fetch_word
);
  // two taken skips, then two skips not taken; elsewhere reads as nop
  always_comb begin
    case (fetch_pc)
      13'h0000: fetch_word = 14'h188A;
      13'h0001: fetch_word = 14'h3E40;
      13'h0002: fetch_word = 14'h1C0A;
      13'h0003: fetch_word = 14'h3E40;
      13'h0004: fetch_word = 14'h180A;
      13'h0005: fetch_word = 14'h3E02;
      13'h0006: fetch_word = 14'h1C8A;
      13'h0007: fetch_word = 14'h3E03;
      default: fetch_word = 14'h0000;
    endcase
  end
endmodule : prog_mem_model

// File: tb/mcu_exec_assertions.sv
// handshake and answer timing checks on the executor's bus ports
// assumes it is bound to mcu_exec_top and sees only its ports
`timescale 1ns/1ps
module mcu_exec_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // a bus write to any address: both write channels taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // answer one cycle after execution, one later behind a nop cycle
  sequence s_wr_answer;
    !s_axi_bvalid ##[1:2] s_axi_bvalid;
  endsequence
  property p_b_lat;
    s_wr_taken |=> s_wr_answer;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("write answer repeated");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write taken while answer pending");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed while waiting");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once)
    else $error("read answer repeated");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while answer pending");
endmodule : mcu_exec_assertions
bind mcu_exec_top mcu_exec_assertions u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// File: tb/mcu_exec_subset_tb_top.sv
// bench: issues instructions and reads state back over the register bus
// assumes the executor's register map and a program memory model
`timescale 1ns/1ps
`include "mcu_exec_map.svh"
module mcu_exec_subset_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [12:0] fetch_pc;
  logic [13:0] fetch_word;
  int error_cnt = 0;
  int n_checks = 0;
  mcu_exec_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  prog_mem_model prog (.fetch_pc, .fetch_word);
  // 100 MHz clock
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////
  // bus write: both channels offered, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // bus read: address held until taken, data taken with rvalid
  task automatic rd(input logic [11:0] a);
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!ar_ok) begin
      @(posedge aclk);
      ar_ok = s_axi_arready;
    end
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    rdata_q = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rc(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    rd(a);
    chk(nm, e, rdata_q);
  endtask : rc
  // byte address of data register f
  function automatic logic [11:0] ra(input logic [6:0] f);
    return 12'h200 + {3'h0, f, 2'h0};
  endfunction : ra
  // call with a given latch and pc, then check pc and stack top
  task automatic do_call(input logic [4:0] lat, input logic [12:0] pc0,
                         input logic [10:0] k);
    wr(`OFF_HIGH_LATCH, {27'h0, lat});
    wr(`OFF_PC, {19'h0, pc0});
    wr(`OFF_INSTR, {18'h0, 3'h4, k});
    rc("call_pc", `OFF_PC, {19'h0, lat[4:3], k});
    rc("stack_top", `OFF_STACK_TOP, {19'h0, pc0 + 13'h1});
  endtask : do_call
  // verdict
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    $display("FAIL watchdog expected done seen hang");
    end_of_test();
  end
  // main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    fetch_pc = 13'h0000;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc("acc", `OFF_ACC, 32'h0);
    rc("pc", `OFF_PC, 32'h0);
    // add immediate: carries out of bits 3 and 7, zero result
    wr(`OFF_ACC, 32'h0F);
    wr(`OFF_INSTR, 32'h3EF1);
    rc("acc", `OFF_ACC, 32'h00);
    rc("status", `OFF_STATUS, 32'h7);
    wr(`OFF_INSTR, 32'h3E01);
    rc("status", `OFF_STATUS, 32'h0);
    // add register, destination acc then register
    wr(ra(7'h7F), 32'h88);
    wr(`OFF_ACC, 32'h88);
    wr(`OFF_INSTR, 32'h077F);
    rc("acc", `OFF_ACC, 32'h10);
    rc("status", `OFF_STATUS, 32'h3);
    rc("reg", ra(7'h7F), 32'h88);
    wr(`OFF_INSTR, 32'h07FF);
    rc("reg", ra(7'h7F), 32'h98);
    rc("acc", `OFF_ACC, 32'h10);
    rc("status", `OFF_STATUS, 32'h0);
    // and immediate keeps carry flags
    wr(`OFF_STATUS, 32'h3);
    wr(`OFF_INSTR, 32'h390F);
    rc("acc", `OFF_ACC, 32'h0);
    rc("status", `OFF_STATUS, 32'h7);
    // and register into register
    wr(ra(7'h05), 32'h3C);
    wr(`OFF_ACC, 32'hF0);
    wr(`OFF_STATUS, 32'h0);
    wr(`OFF_INSTR, 32'h0585);
    rc("reg", ra(7'h05), 32'h30);
    rc("acc", `OFF_ACC, 32'hF0);
    rc("status", `OFF_STATUS, 32'h0);
    // and register into acc leaves the register alone
    wr(`OFF_INSTR, 32'h0505);
    rc("acc", `OFF_ACC, 32'h30);
    rc("reg", ra(7'h05), 32'h30);
    // bit clear and set at every position, flags held set
    wr(`OFF_STATUS, 32'h7);
    for (int b = 0; b < 8; b++) begin
      wr(ra(7'h09), 32'hFF);
      wr(`OFF_INSTR, {18'h0, 4'h4, b[2:0], 7'h09});
      rc("bit_clear", ra(7'h09), 32'hFF & ~(32'h1 << b));
      wr(ra(7'h09), 32'h00);
      wr(`OFF_INSTR, {18'h0, 4'h5, b[2:0], 7'h09});
      rc("bit_set", ra(7'h09), 32'h1 << b);
    end
    rc("status", `OFF_STATUS, 32'h7);
    // skip program fetched from the model
    wr(ra(7'h0A), 32'h01);
    wr(`OFF_ACC, 32'h0);
    wr(`OFF_STATUS, 32'h0);
    wr(`OFF_PC, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rd(`OFF_PC);
      fetch_pc = rdata_q[12:0];
      #1;
      wr(`OFF_INSTR, {18'h0, fetch_word});
      if (i == 0) rc("skip", `OFF_EXEC, 32'h2);
      if (i == 1 || i == 3) rc("acc", `OFF_ACC, 32'h0);
    end
    rc("acc", `OFF_ACC, 32'h5);
    rc("pc", `OFF_PC, 32'h8);
    // calls, upper pc bits from the latch, pc wrap boundary
    do_call(5'h18, 13'h0123, 11'h5A5);
    do_call(5'h10, 13'h1FFF, 11'h7FF);
    // unmapped and read-only places
    rd(12'h01C);
    chk("rresp", {30'h0, `RESP_DECERR}, {30'h0, last_resp});
    chk("rdata", 32'h0, rdata_q);
    wr(12'h020, 32'h1);
    chk("bresp", {30'h0, `RESP_DECERR}, {30'h0, last_resp});
    wr(`OFF_STACK_TOP, 32'h55);
    chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, last_resp});
    rc("stack_top", `OFF_STACK_TOP, 32'h0);
    end_of_test();
  end
endmodule : mcu_exec_subset_tb_top
